// *** cpgo_pkg.sv ***
`default_nettype none
package cpgo_pkg;

  // Register offsets
  localparam logic [7:0] CPGO_OFF_PWR     = 8'h24;
  localparam logic [7:0] CPGO_OFF_CH9_PRI = 8'h25;
  localparam logic [7:0] CPGO_OFF_CH9_SEC = 8'h26;
  localparam logic [7:0] CPGO_OFF_CH10_PRI = 8'h27;
  localparam logic [7:0] CPGO_OFF_CH10_SEC = 8'h28;
  localparam logic [7:0] CPGO_OFF_STATUS  = 8'h30;

  // Field positions in the channel-power register
  localparam int CPGO_DIG_SLEEP_LSB  = 12;
  localparam int CPGO_LINE_SLEEP_LSB = 8;
  localparam int CPGO_ANA_SLEEP_LSB  = 4;
  localparam int CPGO_FLIP_LSB       = 0;

  // Field positions in the gain/offset registers
  localparam int CPGO_GAIN_LSB  = 11;
  localparam int CPGO_GAIN_W    = 5;
  localparam int CPGO_SHIFT_LSB = 0;
  localparam int CPGO_SHIFT_W   = 10;

  // Reset values
  localparam logic [15:0] CPGO_PWR_RST   = 16'h0000;
  localparam logic [4:0]  CPGO_GAIN_RST  = 5'h00;
  localparam logic [9:0]  CPGO_SHIFT_RST = 10'h000;

  // Gain coefficients, fixed point with 12 fractional bits, index N = N x 0.2 dB
  localparam int CPGO_COEF_FRAC = 12;
  localparam logic [14:0] CPGO_COEF_UNITY = 15'h1000;
  localparam logic [0:31][14:0] CPGO_GAIN_Q12 = {
    15'h1000, 15'h105F, 15'h10C1, 15'h1125, 15'h118B, 15'h11F4, 15'h125F, 15'h12CC,
    15'h133C, 15'h13AF, 15'h1425, 15'h149D, 15'h1518, 15'h1595, 15'h1616, 15'h169A,
    15'h1721, 15'h17AA, 15'h1838, 15'h18C8, 15'h195C, 15'h19F3, 15'h1A8E, 15'h1B2C,
    15'h1BCE, 15'h1C74, 15'h1D1D, 15'h1DCB, 15'h1E7D, 15'h1F33, 15'h1FED, 15'h20AB
  };

endpackage
`default_nettype wire

// *** cpgo_regs.sv ***
`timescale 1ns/10ps
`default_nettype none
module cpgo_regs
  import cpgo_pkg::*;
#(
  parameter int DW = 14
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // Register port
  input  wire logic [7:0]            addr,
  input  wire logic [15:0]           wdata,
  input  wire logic                  wr,
  input  wire logic                  rd,
  output logic      [15:0]           rdata,
  // Global enables from the enable register
  input  wire logic                  scale_apply_enable,
  input  wire logic                  shift_apply_enable,
  // Channels 5 to 8, index 0 is channel 5
  input  wire logic [3:0][DW-1:0]    lane_in,
  output logic      [3:0][DW-1:0]    lane_data,
  output logic      [3:0]            digital_sleep,
  output logic      [3:0]            serial_line_sleep,
  output logic      [3:0]            analog_sleep,
  // Channels 9 and 10, index 0 is channel 9
  input  wire logic [1:0][DW-1:0]    ch_in,
  output logic      [1:0][DW-1:0]    ch_data
);

  localparam int PW = DW + 17;

  typedef struct packed {
    logic [15:0]           pwr;
    logic [1:0][4:0]       gain;
    logic [1:0][9:0]       shift_pri;
    logic [1:0][9:0]       shift_sec;
    logic [15:0]           rdata;
    logic [3:0][DW-1:0]    lane;
    logic [1:0][DW:0]      sum;
    logic [1:0][DW-1:0]    chan;
  } cpgo_state_s;

  cpgo_state_s s_reg;
  cpgo_state_s s_next;

  function automatic logic [DW-1:0] cpgo_sat(input logic signed [PW-1:0] v);
    logic [PW-DW:0] top;
    top = v[PW-1:DW-1];
    if (top == '0 || top == '1) begin
      return v[DW-1:0];
    end
    return v[PW-1] ? {1'b1, {(DW-1){1'b0}}} : {1'b0, {(DW-1){1'b1}}};
  endfunction

  function automatic logic signed [PW-1:0] cpgo_widen(input logic [DW:0] v);
    return {{(PW-DW-1){v[DW]}}, v};
  endfunction

  // Offset mirrors disagree; the datapath uses the primary copy only
  logic [1:0] shift_mismatch;
  assign shift_mismatch[0] = s_reg.shift_pri[0] != s_reg.shift_sec[0];
  assign shift_mismatch[1] = s_reg.shift_pri[1] != s_reg.shift_sec[1];

  always_comb begin
    logic [DW:0]          shift_ext;
    logic [14:0]          coef;
    logic signed [PW-1:0] prod;
    shift_ext = '0;
    coef      = CPGO_COEF_UNITY;
    prod      = '0;
    s_next       = s_reg;
    s_next.rdata = '0;

    // Reserved bits are not stored, so they always read back as zero
    if (wr) begin
      unique case (addr)
        CPGO_OFF_PWR: begin
          s_next.pwr = wdata;
        end
        CPGO_OFF_CH9_PRI: begin
          s_next.gain[0]      = wdata[CPGO_GAIN_LSB +: CPGO_GAIN_W];
          s_next.shift_pri[0] = wdata[CPGO_SHIFT_LSB +: CPGO_SHIFT_W];
        end
        CPGO_OFF_CH9_SEC: begin
          s_next.shift_sec[0] = wdata[CPGO_SHIFT_LSB +: CPGO_SHIFT_W];
        end
        CPGO_OFF_CH10_PRI: begin
          s_next.gain[1]      = wdata[CPGO_GAIN_LSB +: CPGO_GAIN_W];
          s_next.shift_pri[1] = wdata[CPGO_SHIFT_LSB +: CPGO_SHIFT_W];
        end
        CPGO_OFF_CH10_SEC: begin
          s_next.shift_sec[1] = wdata[CPGO_SHIFT_LSB +: CPGO_SHIFT_W];
        end
        default: begin
        end
      endcase
    end

    if (rd) begin
      unique case (addr)
        CPGO_OFF_PWR: begin
          s_next.rdata = s_reg.pwr;
        end
        CPGO_OFF_CH9_PRI: begin
          s_next.rdata = {s_reg.gain[0], 1'b0, s_reg.shift_pri[0]};
        end
        CPGO_OFF_CH9_SEC: begin
          s_next.rdata = {6'h00, s_reg.shift_sec[0]};
        end
        CPGO_OFF_CH10_PRI: begin
          s_next.rdata = {s_reg.gain[1], 1'b0, s_reg.shift_pri[1]};
        end
        CPGO_OFF_CH10_SEC: begin
          s_next.rdata = {6'h00, s_reg.shift_sec[1]};
        end
        CPGO_OFF_STATUS: begin
          s_next.rdata = {12'h000, shift_apply_enable, scale_apply_enable, shift_mismatch};
        end
        default: begin
          s_next.rdata = 16'h0000;
        end
      endcase
    end

    // Lanes 5 to 8: a lane with digital or serial-line sleep set holds zero (analog sleep does not), otherwise optional inversion
    for (int i = 0; i < 4; i++) begin
      if (s_reg.pwr[CPGO_DIG_SLEEP_LSB + i] || s_reg.pwr[CPGO_LINE_SLEEP_LSB + i]) begin
        s_next.lane[i] = '0;
      end else if (s_reg.pwr[CPGO_FLIP_LSB + i]) begin
        s_next.lane[i] = ~lane_in[i];
      end else begin
        s_next.lane[i] = lane_in[i];
      end
    end

    // Channels 9 and 10: offset stage, then gain stage
    for (int k = 0; k < 2; k++) begin
      shift_ext = '0;
      if (shift_apply_enable) begin
        shift_ext = {{(DW+1-CPGO_SHIFT_W){s_reg.shift_pri[k][9]}}, s_reg.shift_pri[k]};
      end
      // One guard bit keeps the sum exact; clipping waits for the gain stage
      s_next.sum[k] = {ch_in[k][DW-1], ch_in[k]} + shift_ext;
      coef = scale_apply_enable ? CPGO_GAIN_Q12[s_reg.gain[k]] : CPGO_COEF_UNITY;
      prod = cpgo_widen(s_reg.sum[k]) * $signed({{(PW-15){1'b0}}, coef});
      s_next.chan[k] = cpgo_sat(prod >>> CPGO_COEF_FRAC);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg           <= '0;
      s_reg.pwr       <= CPGO_PWR_RST;
      s_reg.gain      <= {2{CPGO_GAIN_RST}};
      s_reg.shift_pri <= {2{CPGO_SHIFT_RST}};
      s_reg.shift_sec <= {2{CPGO_SHIFT_RST}};
    end else begin
      s_reg <= s_next;
    end
  end

  assign rdata             = s_reg.rdata;
  assign lane_data         = s_reg.lane;
  assign digital_sleep     = s_reg.pwr[CPGO_DIG_SLEEP_LSB +: 4];
  assign serial_line_sleep = s_reg.pwr[CPGO_LINE_SLEEP_LSB +: 4];
  assign analog_sleep      = s_reg.pwr[CPGO_ANA_SLEEP_LSB +: 4];
  assign ch_data           = s_reg.chan;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // Register port steps, shared by the properties below
  sequence pwr_write_s;
    wr && addr == CPGO_OFF_PWR;
  endsequence

  sequence pwr_read_s;
    rd && addr == CPGO_OFF_PWR;
  endsequence

  sequence ch9_write_s;
    wr && addr == CPGO_OFF_CH9_PRI;
  endsequence

  sequence ch9_read_s;
    rd && addr == CPGO_OFF_CH9_PRI;
  endsequence

  sequence ch10_write_s;
    wr && addr == CPGO_OFF_CH10_PRI;
  endsequence

  sequence ch10_read_s;
    rd && addr == CPGO_OFF_CH10_PRI;
  endsequence

  sequence sec_read_s;
    rd && addr == CPGO_OFF_CH10_SEC;
  endsequence

  sequence status_read_s;
    rd && addr == CPGO_OFF_STATUS;
  endsequence

  sequence lane0_live_s;
    !digital_sleep[0] && !serial_line_sleep[0];
  endsequence

  // Channel-power register and lanes 5 to 8
  dig_sleep_a: assert property (pwr_write_s |=> digital_sleep == $past(wdata[15:12]))
    else $error("digital sleep bits not taken from power write");

  dig_zero_a: assert property (digital_sleep[0] |=> lane_data[0] == '0)
    else $error("sleeping digital block of channel 5 carries data");

  line_write_a: assert property (
    pwr_write_s |=> serial_line_sleep == $past(wdata[11:8]))
    else $error("line sleep bits not taken from power write");

  line_sleep_a: assert property (serial_line_sleep[3] |=> lane_data[3] == '0)
    else $error("sleeping serial line 8 carries data");

  line_zero_a: assert property (serial_line_sleep[0] |=> lane_data[0] == '0)
    else $error("sleeping serial line 5 carries data");

  ana_sleep_a: assert property (pwr_write_s |=> analog_sleep == $past(wdata[7:4]))
    else $error("analog sleep bits not taken from power write");

  flip_write_a: assert property (
    pwr_write_s |=> s_reg.pwr[CPGO_FLIP_LSB +: 4] == $past(wdata[3:0]))
    else $error("inversion bits not taken from power write");

  lane_flip_a: assert property (
    lane0_live_s ##0 s_reg.pwr[CPGO_FLIP_LSB] |=> lane_data[0] == ~$past(lane_in[0]))
    else $error("lane 5 data not inverted");

  flip3_a: assert property (
    !digital_sleep[3] && !serial_line_sleep[3] && s_reg.pwr[CPGO_FLIP_LSB + 3]
      |=> lane_data[3] == ~$past(lane_in[3]))
    else $error("lane 8 data not inverted");

  lane_pass_a: assert property (
    lane0_live_s ##0 !s_reg.pwr[CPGO_FLIP_LSB] |=> lane_data[0] == $past(lane_in[0]))
    else $error("lane 5 data altered without inversion");

  pwr_read_a: assert property (pwr_read_s |=> rdata == $past(s_reg.pwr))
    else $error("power register readback wrong");

  // Without a write the controls must not drift
  pwr_hold_a: assert property (
    !(wr && addr == CPGO_OFF_PWR) |=> $stable(s_reg.pwr))
    else $error("power register changed without a write");

  // Gain and offset registers of channels 9 and 10
  gain_write_a: assert property (
    ch9_write_s |=> s_reg.gain[0] == $past(wdata[15:11]))
    else $error("channel 9 gain field not stored");

  shift_write_a: assert property (
    ch9_write_s |=> s_reg.shift_pri[0] == $past(wdata[9:0]))
    else $error("channel 9 offset field not stored");

  sec_write_a: assert property (
    wr && addr == CPGO_OFF_CH9_SEC |=> s_reg.shift_sec[0] == $past(wdata[9:0]))
    else $error("channel 9 mirror offset not stored");

  pri_read_a: assert property (
    ch9_read_s |=> rdata == {$past(s_reg.gain[0]), 1'b0, $past(s_reg.shift_pri[0])})
    else $error("primary register readback layout wrong");

  pri10_read_a: assert property (
    ch10_read_s |=> rdata == {$past(s_reg.gain[1]), 1'b0, $past(s_reg.shift_pri[1])})
    else $error("channel 10 primary readback layout wrong");

  pri_write_a: assert property (
    ch10_write_s |=> s_reg.gain[1] == $past(wdata[15:11])
      && s_reg.shift_pri[1] == $past(wdata[9:0]))
    else $error("primary register fields not stored");

  sec_read_a: assert property (
    sec_read_s |=> rdata == {6'h00, $past(s_reg.shift_sec[1])})
    else $error("channel 10 mirror readback wrong");

  // Status shows the enables and whether the channel 9 mirror pair disagrees
  status_read_a: assert property (
    status_read_s |=> rdata[3:2] == $past({shift_apply_enable, scale_apply_enable})
      && rdata[0] == ($past(s_reg.shift_pri[0]) != $past(s_reg.shift_sec[0])))
    else $error("status readback wrong");

  // A read answer lasts one cycle, so stale data never looks fresh
  read_once_a: assert property (!rd |=> rdata == 16'h0000)
    else $error("read data held beyond one cycle");

  // Datapath of channels 9 and 10
  unity_gain_a: assert property (
    scale_apply_enable && s_reg.gain[0] == 5'h00
      |=> ch_data[0] == cpgo_sat(cpgo_widen($past(s_reg.sum[0]))))
    else $error("gain code zero is not unity");

  // Any code above zero must lift a mid-range positive sum by at least one step
  gain_up_a: assert property (
    scale_apply_enable && s_reg.gain[0] != 5'h00 && s_reg.sum[0][DW:DW-2] == 3'b000
      && s_reg.sum[0][DW-3:6] != '0 |=> ch_data[0] > $past(s_reg.sum[0][DW-1:0]))
    else $error("nonzero gain code does not raise the sample");

  gain_off_a: assert property (
    !scale_apply_enable |=> ch_data[1] == cpgo_sat(cpgo_widen($past(s_reg.sum[1]))))
    else $error("gain applied while gain enable is clear");

  shift_raw_a: assert property (
    !shift_apply_enable |=> s_reg.sum[0] == $past({ch_in[0][DW-1], ch_in[0]}))
    else $error("offset added while offset enable is clear");

  // Both enables clear: the sample crosses both stages untouched
  shift_off_a: assert property (
    !shift_apply_enable ##1 !scale_apply_enable |=> ch_data[0] == $past(ch_in[0], 2))
    else $error("offset applied while offset enable is clear");

  // Sign extension of the offset, checked on the stage register
  shift_sign_a: assert property (
    shift_apply_enable |=> s_reg.sum[1] ==
      $past({ch_in[1][DW-1], ch_in[1]})
      + $past({{(DW+1-CPGO_SHIFT_W){s_reg.shift_pri[1][9]}}, s_reg.shift_pri[1]}))
    else $error("offset not added as signed value");

  neg_shift_a: assert property (
    shift_apply_enable && s_reg.shift_pri[0][9] && !ch_in[0][DW-1] && ch_in[0][DW-2:9] != '0
      |=> s_reg.sum[0] < $past({1'b0, ch_in[0]}))
    else $error("negative offset does not lower the sample");

endmodule
`default_nettype wire

// *** cpgo_host.sv ***
`timescale 1ns/10ps
`default_nettype none
module cpgo_host
  import cpgo_pkg::*;
(
  // Clock
  input  wire logic        clk,
  // Register port
  output logic      [7:0]  addr,
  output logic      [15:0] wdata,
  output logic             wr,
  output logic             rd,
  input  wire logic [15:0] rdata
);
  initial begin
    addr = 8'h00;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
  end

  // Strobe drops on the taking edge, so back-to-back calls leave one idle cycle
  task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic read_reg(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  // Mirror register gets the same offset; reserved bits always sent as zero
  task automatic set_channel(input int ch, input logic [4:0] g, input logic [9:0] off);
    write_reg((ch == 9) ? CPGO_OFF_CH9_PRI : CPGO_OFF_CH10_PRI, {g, 1'b0, off});
    write_reg((ch == 9) ? CPGO_OFF_CH9_SEC : CPGO_OFF_CH10_SEC, {6'h00, off});
  endtask
endmodule
`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import cpgo_pkg::*;
  logic             clk;
  logic             rst;
  logic [7:0]       addr;
  logic [15:0]      wdata;
  logic             wr;
  logic             rd;
  logic [15:0]      rdata;
  logic             scale_apply_enable;
  logic             shift_apply_enable;
  logic [3:0][13:0] lane_in;
  logic [3:0][13:0] lane_data;
  logic [3:0]       digital_sleep;
  logic [3:0]       serial_line_sleep;
  logic [3:0]       analog_sleep;
  logic [1:0][13:0] ch_in;
  logic [1:0][13:0] ch_data;
  int               err_count;
  int               checks;
  int               seed;

  cpgo_regs #(.DW(14)) i_cpgo_regs (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .scale_apply_enable(scale_apply_enable),
    .shift_apply_enable(shift_apply_enable), .lane_in(lane_in), .lane_data(lane_data),
    .digital_sleep(digital_sleep), .serial_line_sleep(serial_line_sleep),
    .analog_sleep(analog_sleep), .ch_in(ch_in), .ch_data(ch_data));
  cpgo_host i_cpgo_host (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk_reg(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_smp(input string name, input logic [13:0] exp, input logic [13:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Gain computed from dB directly rather than from a stored table
  function automatic logic [13:0] exp_ch(logic [13:0] x, logic [9:0] off, logic [4:0] g,
                                         logic se, logic ge);
    longint s;
    longint c;
    longint p;
    s = longint'($signed(x)) + (se ? longint'($signed(off)) : 0);
    c = ge ? longint'($rtoi($pow(10.0, g * 0.01) * 4096.0 + 0.5)) : 4096;
    p = (s * c) >>> 12;
    if (p > 8191) p = 8191;
    if (p < -8192) p = -8192;
    return p[13:0];
  endfunction

  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    finish_test();
  end

  initial begin
    logic [7:0]       map [6];
    logic [15:0]      pw;
    logic [15:0]      d;
    logic [3:0][13:0] lin;
    logic [13:0]      x;
    logic [9:0]       off;
    logic [4:0]       g;
    logic             se;
    logic             ge;
    int               ch;
    map = '{CPGO_OFF_PWR, CPGO_OFF_CH9_PRI, CPGO_OFF_CH9_SEC, CPGO_OFF_CH10_PRI,
            CPGO_OFF_CH10_SEC, 8'h31};
    seed = 32'h8CC7;
    err_count = 0;
    checks = 0;
    rst = 1'b1;
    scale_apply_enable = 1'b0;
    shift_apply_enable = 1'b0;
    lane_in = '0;
    ch_in = '0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      i_cpgo_host.read_reg(map[i], d);
      chk_reg("reset value", 16'h0000, d);
    end
    for (int i = 0; i < 8; i++) begin
      pw = (i == 0) ? 16'hFFFF : 16'($random(seed));
      i_cpgo_host.write_reg(CPGO_OFF_PWR, pw);
      i_cpgo_host.read_reg(CPGO_OFF_PWR, d);
      chk_reg("power readback", pw, d);
      chk_reg("digital sleep", {12'h000, pw[15:12]}, {12'h000, digital_sleep});
      chk_reg("line sleep", {12'h000, pw[11:8]}, {12'h000, serial_line_sleep});
      chk_reg("analog sleep", {12'h000, pw[7:4]}, {12'h000, analog_sleep});
      for (int k = 0; k < 4; k++) lin[k] = 14'($random(seed));
      @(posedge clk);
      lane_in <= lin;
      @(posedge clk);
      #1;
      for (int k = 0; k < 4; k++)
        chk_smp("lane out", (pw[12+k] | pw[8+k]) ? 14'h0000 :
                pw[k] ? ~lin[k] : lin[k], lane_data[k]);
    end
    for (int i = 0; i < 16; i++) begin
      ch = 9 + (i % 2);
      g = (i < 2) ? 5'h1F : 5'($random(seed));
      off = (i == 0) ? 10'h200 : (i == 1) ? 10'h1FF : 10'($random(seed));
      x = (i == 0) ? 14'h2000 : (i == 1) ? 14'h1FFF : 14'($random(seed));
      se = (i < 2) ? 1'b1 : 1'($random(seed));
      ge = (i < 2) ? 1'b1 : 1'($random(seed));
      i_cpgo_host.set_channel(ch, g, off);
      i_cpgo_host.read_reg((ch == 9) ? CPGO_OFF_CH9_PRI : CPGO_OFF_CH10_PRI, d);
      chk_reg("primary readback", {g, 1'b0, off}, d);
      i_cpgo_host.read_reg((ch == 9) ? CPGO_OFF_CH9_SEC : CPGO_OFF_CH10_SEC, d);
      chk_reg("secondary readback", {6'h00, off}, d);
      @(posedge clk);
      scale_apply_enable <= ge;
      shift_apply_enable <= se;
      ch_in[ch-9] <= x;
      repeat (2) @(posedge clk);
      #1;
      chk_smp("channel out", exp_ch(x, off, g, se, ge), ch_data[ch-9]);
      i_cpgo_host.read_reg(CPGO_OFF_STATUS, d);
      chk_reg("status", {12'h000, se, ge, 2'b00}, d);
    end
    // Host breaks the mirror rule on purpose so the mismatch flag is seen
    i_cpgo_host.write_reg(CPGO_OFF_CH9_PRI, 16'h0155);
    i_cpgo_host.write_reg(CPGO_OFF_CH9_SEC, 16'h02AA);
    i_cpgo_host.read_reg(CPGO_OFF_STATUS, d);
    chk_reg("mirror mismatch", {12'h000, se, ge, 2'b01}, d);
    finish_test();
  end
endmodule
`default_nettype wire
